//--- logic/ecs_pkg.sv
package ecs_pkg;
   // ----------------------------------------
   // Widths, codes and field positions.
   // ----------------------------------------
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
   localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
   localparam logic [6:0] SLAVE_ADDR = 7'h32;
   localparam logic [2:0] CLR_PATTERN = 3'h2;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [7:0] FILL_BYTE = 8'hff;
   localparam int PTR_BIT = 7;
   localparam logic [2:0] IDX_ADDR = 3'h0;
   localparam logic [2:0] IDX_PTR = 3'h1;
   localparam logic [2:0] BYTE_HI = 3'h1;
   localparam logic [2:0] BYTE_MID = 3'h2;
   localparam logic [2:0] BYTE_LO = 3'h3;
   localparam logic [2:0] DATA_LAST = 3'h4;
   localparam logic [2:0] IDX_SAT = 3'h7;
   // ----------------------------------------
   // Pin synchroniser lanes.
   // ----------------------------------------
   localparam int SY_W = 4;
   localparam int SY_SCL = 0;
   localparam int SY_SDA = 1;
   localparam int SY_CIN = 2;
   localparam int SY_RSTN = 3;
   localparam logic [SY_W-1:0] SY_INIT = 4'hf;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RECV = 3'h1,
      ST_SACK = 3'h2,
      ST_SEND = 3'h3,
      ST_MACK = 3'h4
   } ecs_state_t;

   // Picks the byte sent at a given read position; past the register, ones.
   function automatic logic [7:0] ecs_byte_sel(input logic [CNT_W-1:0] v, input logic [2:0] k);
      unique case (k)
         BYTE_HI: ecs_byte_sel = v[23:16];
         BYTE_MID: ecs_byte_sel = v[15:8];
         BYTE_LO: ecs_byte_sel = v[7:0];
         default: ecs_byte_sel = FILL_BYTE;
      endcase
   endfunction

   // Advances a byte position and holds it at its top value.
   function automatic logic [2:0] ecs_bump(input logic [2:0] k);
      ecs_bump = (k == IDX_SAT) ? k : k + 3'h1;
   endfunction
endpackage

//--- logic/ecs_sync.sv
module ecs_sync import ecs_pkg::*; #(
   parameter int W = SY_W,
   parameter logic [W-1:0] INIT = SY_INIT
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ecs_sync_t;

   ecs_sync_t s;
   ecs_sync_t next_s;

   always_comb begin
      next_s.s1 = d;
      next_s.s2 = s.s1;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= {INIT, INIT};
      end else begin
         s <= next_s;
      end
   end

   assign q = s.s2;
endmodule

//--- logic/ecs_counter.sv
module ecs_counter import ecs_pkg::*; (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic inc,
   input wire logic clr,
   output logic [CNT_W-1:0] count,
   output logic wrap
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic wrap;
   } ecs_counter_t;

   ecs_counter_t s;
   ecs_counter_t next_s;

   always_comb begin
      next_s = s;
      if (clr) begin
         next_s.cnt = CNT_ZERO;
         next_s.wrap = 1'b0;
      end else if (inc) begin
         next_s.cnt = s.cnt + CNT_ONE;
         if (s.cnt == CNT_MAX) begin
            next_s.wrap = ~s.wrap;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{cnt: CNT_ZERO, wrap: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign count = s.cnt;
   assign wrap = s.wrap;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_count_step: assert property (inc && !clr && s.cnt != CNT_MAX |=>
      s.cnt == $past(s.cnt) + CNT_ONE && $stable(s.wrap))
      else $error("counter did not step by one");
   a_wrap_toggle: assert property (inc && !clr && s.cnt == CNT_MAX |=>
      s.cnt == CNT_ZERO && s.wrap != $past(s.wrap))
      else $error("wrap did not clear count and toggle flag");
   a_clear_all: assert property (clr |=> s.cnt == CNT_ZERO && !s.wrap)
      else $error("clear left count or flag set");
endmodule

//--- logic/ecs_top.sv
module ecs_top import ecs_pkg::*; (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_b,
   input wire logic count_input,
   input wire logic reset_n_pin,
   output logic wrap_toggle_out
);
   // ----------------------------------------
   // State.
   // ----------------------------------------
   typedef struct packed {
      ecs_state_t st;
      logic [3:0] bcnt;
      logic [7:0] sh;
      logic [2:0] bidx;
      logic rw;
      logic ptr;
      logic mnack;
      logic [CNT_W-1:0] snap;
      logic [CNT_W-1:0] wbuf;
      logic [CNT_W-1:0] user;
      logic busy;
      logic cin_start;
      logic scl_p;
      logic sda_p;
      logic cin_p;
      logic clr_req;
      logic sda_oe_b;
      logic sda_out;
   } ecs_top_state_t;

   localparam ecs_top_state_t TOP_INIT = '{
      st: ST_IDLE,
      bcnt: 4'h0,
      sh: 8'h00,
      bidx: IDX_ADDR,
      rw: 1'b0,
      ptr: 1'b1,
      mnack: 1'b0,
      snap: CNT_ZERO,
      wbuf: CNT_ZERO,
      user: CNT_ZERO,
      busy: 1'b0,
      cin_start: 1'b0,
      scl_p: 1'b1,
      sda_p: 1'b1,
      cin_p: 1'b1,
      clr_req: 1'b0,
      sda_oe_b: 1'b1,
      sda_out: 1'b0
   };

   ecs_top_state_t s;
   ecs_top_state_t next_s;

   logic [SY_W-1:0] sy;
   logic sy_scl;
   logic sy_sda;
   logic sy_cin;
   logic sy_rstn;
   logic scl_rise;
   logic scl_fall;
   logic cin_rise;
   logic start_det;
   logic stop_det;
   logic byte_end;
   logic cnt_inc;
   logic cnt_clr;
   logic [CNT_W-1:0] count;
   logic [7:0] rd_byte;
   logic [7:0] first_byte;

   // ----------------------------------------
   // Pin synchronisers and edge detection.
   // ----------------------------------------
   ecs_sync #(
      .W(SY_W),
      .INIT(SY_INIT)
   ) u_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .d({reset_n_pin, count_input, sda_in, scl}),
      .q(sy)
   );

   assign sy_scl = sy[SY_SCL];
   assign sy_sda = sy[SY_SDA];
   assign sy_cin = sy[SY_CIN];
   assign sy_rstn = sy[SY_RSTN];
   assign scl_rise = sy_scl & ~s.scl_p;
   assign scl_fall = ~sy_scl & s.scl_p;
   assign cin_rise = sy_cin & ~s.cin_p;
   assign start_det = sy_scl & s.scl_p & s.sda_p & ~sy_sda;
   assign stop_det = sy_scl & s.scl_p & ~s.sda_p & sy_sda;
   assign byte_end = (s.st == ST_RECV) && scl_fall && (s.bcnt == BYTE_BITS) && !start_det && !stop_det;

   // ----------------------------------------
   // Event counter.
   // ----------------------------------------
   assign cnt_inc = (cin_rise & ~s.busy & ~start_det)
      | (stop_det & s.busy & ~s.cin_start & sy_cin);
   assign cnt_clr = ~sy_rstn | s.clr_req;

   ecs_counter u_counter (
      .mclk(mclk),
      .rst_b(rst_b),
      .inc(cnt_inc),
      .clr(cnt_clr),
      .count(count),
      .wrap(wrap_toggle_out)
   );

   assign rd_byte = ecs_byte_sel(s.snap, ecs_bump(s.bidx));
   assign first_byte = ecs_byte_sel(s.snap, s.bidx);

   // ----------------------------------------
   // Serial slave.
   // ----------------------------------------
   always_comb begin
      next_s = s;
      next_s.scl_p = sy_scl;
      next_s.sda_p = sy_sda;
      next_s.cin_p = sy_cin;
      next_s.clr_req = 1'b0;
      next_s.sda_out = 1'b0;
      if (start_det) begin
         next_s.st = ST_RECV;
         next_s.bcnt = 4'h0;
         next_s.bidx = IDX_ADDR;
         next_s.sda_oe_b = 1'b1;
         next_s.busy = 1'b1;
         if (!s.busy) begin
            next_s.cin_start = sy_cin;
         end
      end else if (stop_det) begin
         next_s.st = ST_IDLE;
         next_s.sda_oe_b = 1'b1;
         next_s.busy = 1'b0;
         next_s.ptr = 1'b1;
      end else begin
         unique case (s.st)
            ST_IDLE: begin
               next_s.sda_oe_b = 1'b1;
            end
            ST_RECV: begin
               if (scl_rise) begin
                  next_s.sh = {s.sh[6:0], sy_sda};
                  next_s.bcnt = s.bcnt + 4'h1;
               end else if (byte_end) begin
                  next_s.bcnt = 4'h0;
                  next_s.bidx = ecs_bump(s.bidx);
                  if (s.bidx == IDX_ADDR) begin
                     if (s.sh[7:1] == SLAVE_ADDR) begin
                        next_s.st = ST_SACK;
                        next_s.sda_oe_b = 1'b0;
                        next_s.rw = s.sh[0];
                        next_s.snap = s.ptr ? count : s.user;
                     end else begin
                        next_s.st = ST_IDLE;
                     end
                  end else begin
                     next_s.st = ST_SACK;
                     next_s.sda_oe_b = 1'b0;
                     if (s.bidx == IDX_PTR) begin
                        next_s.ptr = s.sh[PTR_BIT];
                     end else if (s.bidx <= DATA_LAST) begin
                        next_s.wbuf = {s.wbuf[15:0], s.sh};
                     end
                     if (s.bidx == DATA_LAST) begin
                        next_s.user = {s.wbuf[15:0], s.sh};
                        next_s.clr_req = (s.sh[2:0] == CLR_PATTERN);
                     end
                  end
               end
            end
            ST_SACK: begin
               if (scl_fall) begin
                  next_s.bcnt = 4'h0;
                  if (s.rw) begin
                     next_s.st = ST_SEND;
                     next_s.sda_oe_b = first_byte[7];
                     next_s.sh = {first_byte[6:0], 1'b0};
                  end else begin
                     next_s.st = ST_RECV;
                     next_s.sda_oe_b = 1'b1;
                  end
               end
            end
            ST_SEND: begin
               if (scl_rise) begin
                  next_s.bcnt = s.bcnt + 4'h1;
               end else if (scl_fall) begin
                  if (s.bcnt == BYTE_BITS) begin
                     next_s.st = ST_MACK;
                     next_s.sda_oe_b = 1'b1;
                     next_s.bcnt = 4'h0;
                  end else begin
                     next_s.sda_oe_b = s.sh[7];
                     next_s.sh = {s.sh[6:0], 1'b0};
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  next_s.mnack = sy_sda;
               end else if (scl_fall) begin
                  if (s.mnack) begin
                     next_s.st = ST_IDLE;
                  end else begin
                     next_s.st = ST_SEND;
                     next_s.bidx = ecs_bump(s.bidx);
                     next_s.sda_oe_b = rd_byte[7];
                     next_s.sh = {rd_byte[6:0], 1'b0};
                  end
               end
            end
            default: begin
               next_s.st = ST_IDLE;
               next_s.sda_oe_b = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= TOP_INIT;
      end else begin
         s <= next_s;
      end
   end

   assign sda_out = s.sda_out;
   assign sda_oe_b = s.sda_oe_b;

   // ----------------------------------------
   // Checks.
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_count_frozen: assert property (s.busy && cin_rise && !cnt_clr && !stop_det |=>
      $stable(count))
      else $error("count moved during an access");

   a_stop_bump: assert property (stop_det && s.busy && !s.cin_start && sy_cin && !cnt_clr |=>
      count == $past(count) + CNT_ONE)
      else $error("no single step at stop");

   a_start_recv: assert property (start_det |=>
      s.st == ST_RECV && s.bcnt == 4'h0 && s.busy && s.sda_oe_b)
      else $error("start did not open an access");

   a_stop_idle: assert property (stop_det |=>
      s.st == ST_IDLE && s.ptr && !s.busy && s.sda_oe_b)
      else $error("stop did not close the access");

   a_addr_ack: assert property (byte_end && s.bidx == IDX_ADDR && s.sh[7:1] == SLAVE_ADDR |=>
      s.st == ST_SACK && !sda_oe_b)
      else $error("own address not acknowledged");

   a_ack_hold: assert property (s.st == ST_SACK && !scl_fall && !start_det && !stop_det |=>
      !sda_oe_b)
      else $error("acknowledge released early");

   a_clear_cmd: assert property (byte_end && s.bidx == DATA_LAST && s.sh[2:0] == CLR_PATTERN |=>
      ##1 count == CNT_ZERO && !wrap_toggle_out)
      else $error("clear command did not clear");

   a_user_keep: assert property (byte_end && s.bidx == DATA_LAST |=>
      s.user == {$past(s.wbuf[15:0]), $past(s.sh)})
      else $error("user word not stored");

   a_fill_ones: assert property (s.st == ST_MACK && scl_fall && !s.mnack && s.bidx >= BYTE_LO
      && !start_det && !stop_det |=> sda_oe_b)
      else $error("read past register not all ones");

   a_snap_take: assert property (byte_end && s.bidx == IDX_ADDR && s.sh[7:1] == SLAVE_ADDR |=>
      s.snap == ($past(s.ptr) ? $past(count) : $past(s.user)))
      else $error("read snapshot taken from wrong source");

   a_ptr_load: assert property (byte_end && s.bidx == IDX_PTR |=>
      s.ptr == $past(s.sh[PTR_BIT]))
      else $error("pointer bit not taken");

   a_data_ack: assert property (byte_end && s.bidx != IDX_ADDR |=>
      s.st == ST_SACK && !sda_oe_b)
      else $error("data byte not acknowledged");

   a_bit_shift: assert property (s.st == ST_RECV && scl_rise && !start_det && !stop_det |=>
      s.sh[0] == $past(sy_sda) && s.bcnt == $past(s.bcnt) + 4'h1)
      else $error("data bit not shifted in");

   a_send_bit: assert property (s.st == ST_SEND && scl_fall && s.bcnt != BYTE_BITS
      && !start_det && !stop_det |=> sda_oe_b == $past(s.sh[7]))
      else $error("read bit sent out of order");

   a_nack_idle: assert property (s.st == ST_MACK && scl_fall && s.mnack
      && !start_det && !stop_det |=> s.st == ST_IDLE && sda_oe_b)
      else $error("no-acknowledge did not end the read");

   a_abort_byte: assert property (s.st == ST_RECV && s.bcnt != 4'h0 && stop_det |=>
      s.st == ST_IDLE && !s.busy)
      else $error("mid-byte stop did not abort the access");

   a_cin_hold: assert property (start_det && !s.busy |=> s.cin_start == $past(sy_cin))
      else $error("count input level at start not kept");

   a_clear_guard: assert property (byte_end && s.bidx == DATA_LAST && s.sh[2:0] != CLR_PATTERN |=>
      !s.clr_req)
      else $error("clear raised for another pattern");

   a_pin_clear: assert property (!sy_rstn |=> count == CNT_ZERO && !wrap_toggle_out)
      else $error("reset pin did not clear count and flag");
endmodule

//--- tb/ecs_master_model.sv
module ecs_master_model (
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic oe_b
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // Bus idles released, SCL high.
   // ----------------------------------------
   initial begin
      scl = 1'b1;
      oe_b = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // SDA falls while SCL is high; also serves as repeated start.
   task automatic start();
      tick(1);
      oe_b <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      oe_b <= 1'b0;
      tick(4);
      scl <= 1'b0;
   endtask

   // SDA rises while SCL is high.
   task automatic stop();
      tick(2);
      oe_b <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      oe_b <= 1'b1;
      tick(4);
   endtask

   // One clock of 80 ns; SDA moves only while SCL is low.
   task automatic bit_x(input logic b, output logic r);
      tick(2);
      oe_b <= b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      r = sda;
      scl <= 1'b0;
   endtask

   // Eight bits MSB first, then the receiver's acknowledge clock.
   task automatic wbyte(input logic [7:0] d, output logic ack_n);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, ack_n);
   endtask

   // Reads a byte and answers with an acknowledge or a no-acknowledge.
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(nack, r);
   endtask
endmodule

//--- tb/ecs_top_tb.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module ecs_top_tb import ecs_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk, rst_b, count_input, reset_n_pin, sda_out, sda_oe_b, wrap_toggle_out;
   logic m_scl, m_oe_b, sda_wire, a;
   logic [23:0] v, prev, exp_u;
   int bad_count, n_tests, cycles;

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   assign sda_wire = ((sda_oe_b == 1'b0 && sda_out == 1'b0) || m_oe_b == 1'b0) ? 1'b0 : 1'b1;

   ecs_top i_dut (.mclk(mclk), .rst_b(rst_b), .scl(m_scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe_b(sda_oe_b), .count_input(count_input), .reset_n_pin(reset_n_pin),
      .wrap_toggle_out(wrap_toggle_out));
   ecs_master_model i_mst (.mclk(mclk), .sda(sda_wire), .scl(m_scl), .oe_b(m_oe_b));

   // ----------------------------------------
   // Access tasks.
   // ----------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge mclk);
         count_input <= 1'b1;
         repeat (4) @(posedge mclk);
         count_input <= 1'b0;
         repeat (3) @(posedge mclk);
      end
   endtask

   task automatic read_count(output logic [23:0] val);
      logic k_a;
      logic [7:0] x;
      i_mst.start();
      i_mst.wbyte({SLAVE_ADDR, 1'b1}, k_a);
      `CHK("address ack", 1'b0, k_a)
      for (int k = 2; k >= 0; k--) begin
         i_mst.rbyte(1'b0, x);
         val[k*8 +: 8] = x;
      end
      i_mst.rbyte(1'b1, x);
      `CHK("fill byte", FILL_BYTE, x)
      i_mst.stop();
   endtask

   task automatic write_user(input logic [7:0] ptr, input logic [23:0] d);
      logic k_a, acc;
      i_mst.start();
      i_mst.wbyte({SLAVE_ADDR, 1'b0}, acc);
      i_mst.wbyte(ptr, k_a);
      acc = acc | k_a;
      for (int k = 2; k >= 0; k--) begin
         i_mst.wbyte(d[k*8 +: 8], k_a);
         acc = acc | k_a;
      end
      `CHK("write acks", 1'b0, acc)
      i_mst.stop();
   endtask

   task automatic read_user(output logic [23:0] val);
      logic k_a;
      logic [7:0] x;
      i_mst.start();
      i_mst.wbyte({SLAVE_ADDR, 1'b0}, k_a);
      i_mst.wbyte(8'h01, k_a);
      i_mst.start();
      i_mst.wbyte({SLAVE_ADDR, 1'b1}, k_a);
      for (int k = 2; k >= 0; k--) begin
         i_mst.rbyte(k == 0, x);
         val[k*8 +: 8] = x;
      end
      i_mst.stop();
   endtask

   // ----------------------------------------
   // Timeout.
   // ----------------------------------------
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         $display("[FAIL] timeout expected end seen %0d cycles", cycles);
         wrap_up();
      end
   end

   // ----------------------------------------
   // Tests.
   // ----------------------------------------
   initial begin
      rst_b = 1'b0;
      count_input = 1'b0;
      reset_n_pin = 1'b1;
      bad_count = 0;
      n_tests = 0;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK("flag at reset", 1'b0, wrap_toggle_out)
      read_count(v);
      `CHK("count at reset", CNT_ZERO, v)
      pulse(5);
      read_count(v);
      `CHK("count after pulses", 24'h000005, v)
      i_mst.start();
      i_mst.wbyte({SLAVE_ADDR ^ 7'h01, 1'b1}, a);
      `CHK("foreign address ack", 1'b1, a)
      i_mst.stop();
      i_mst.start();
      i_mst.bit_x(1'b0, a);
      i_mst.bit_x(1'b1, a);
      i_mst.stop();
      read_count(v);
      `CHK("count after abort", 24'h000005, v)
      write_user(8'h81, 24'habcdef);
      read_user(v);
      `CHK("user readback", 24'habcdef, v)
      read_count(v);
      `CHK("count after user write", 24'h000005, v)
      for (int p = 0; p < 8; p++) begin
         pulse(2);
         read_count(prev);
         exp_u = {21'h1a2b3c, p[2:0]};
         write_user(8'h81, exp_u);
         read_count(v);
         `CHK("count after command", (p == 2) ? CNT_ZERO : prev, v)
         read_user(v);
         `CHK("user after command", exp_u, v)
      end
      pulse(3);
      read_count(prev);
      i_mst.start();
      i_mst.wbyte({SLAVE_ADDR, 1'b1}, a);
      pulse(3);
      @(posedge mclk);
      count_input <= 1'b1;
      for (int k = 2; k >= 0; k--) begin
         i_mst.rbyte(k == 0, v[k*8 +: 8]);
      end
      i_mst.stop();
      `CHK("snapshot in access", prev, v)
      @(posedge mclk);
      count_input <= 1'b0;
      read_count(v);
      `CHK("one step at stop", prev + CNT_ONE, v)
      @(posedge mclk);
      reset_n_pin <= 1'b0;
      repeat (6) @(posedge mclk);
      reset_n_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      read_count(v);
      `CHK("count after pin", CNT_ZERO, v)
      `CHK("flag after pin", 1'b0, wrap_toggle_out)
      read_user(v);
      `CHK("user kept by pin", exp_u, v)
      wrap_up();
   end
endmodule
